// ===== src/smcr_regs.sv
// Configuration register bank of a pressure/temperature sensor.
// Assumes a serial engine on lclk issues accesses; measurement core on mclk.
`timescale 1ns/1ps
`default_nettype none
`include "smcr_defines.svh"
module smcr_regs
    import smcr_pkg::*;
#(
    parameter int WDT_SHORT_CYC = `SMCR_WDT_SHORT_US_X100 * `SMCR_CLK_MHZ / 100,
    parameter int WDT_LONG_CYC = `SMCR_WDT_LONG_US * `SMCR_CLK_MHZ
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic lclk,
    input wire logic lk_req,
    input wire smcr_req_s lk_cmd,
    output logic lk_busy,
    output logic lk_rvalid,
    output logic [7:0] lk_rdata,
    input wire smcr_evt_s evt,
    input wire logic sample_in,
    input wire logic meas_tick,
    input wire logic meas_done,
    input wire logic bus_active,
    input wire logic bus_kick,
    input wire logic [1:0] nvm_wdt,
    output logic fifo_push,
    output logic filt_select,
    output logic three_wire_select,
    output logic press_conv_en,
    output logic temperature_conv_en,
    output logic [2:0] press_oversample,
    output logic [2:0] temperature_oversample,
    output logic meas_start,
    output logic wdt_expire,
    output logic irq_out,
    output logic irq_oe
);
    // Link domain: request word captured once and held, so the core may read it late
    smcr_req_s hold_q;
    logic req_tgl_q;
    logic ack_s1_q;
    logic ack_s2_q;
    logic ack_s3_q;
    logic busy_q;
    logic rvalid_q;
    logic [7:0] lk_rdata_q;
    logic ack_tgl_q;
    logic [7:0] rdata_q;
    wire ack_seen = ack_s2_q ^ ack_s3_q;

    // Accept one access at a time; held stable until the answer returns
    always_ff @(posedge lclk or negedge rst_n) begin
        if (!rst_n) begin
            hold_q <= '0;
            req_tgl_q <= 1'b0;
            busy_q <= 1'b0;
        end else if (lk_req && !busy_q) begin
            hold_q <= lk_cmd;
            req_tgl_q <= ~req_tgl_q;
            busy_q <= 1'b1;
        end else if (ack_seen) begin
            busy_q <= 1'b0;
        end
    end

    // Answer toggle back from the register domain
    // Busy drops on the same edge that shows read data and valid
    always_ff @(posedge lclk or negedge rst_n) begin
        if (!rst_n) begin
            ack_s1_q <= 1'b0;
            ack_s2_q <= 1'b0;
            ack_s3_q <= 1'b0;
            rvalid_q <= 1'b0;
            lk_rdata_q <= 8'h00;
        end else begin
            ack_s1_q <= ack_tgl_q;
            ack_s2_q <= ack_s1_q;
            ack_s3_q <= ack_s2_q;
            rvalid_q <= ack_seen && !hold_q.we;
            // Read word is static in mclk while the request is outstanding
            if (ack_seen) lk_rdata_q <= rdata_q;
        end
    end
    assign lk_busy = busy_q;
    assign lk_rvalid = rvalid_q;
    assign lk_rdata = lk_rdata_q;

    // Register domain; two stages settle the toggle, the third marks its edge
    logic rq_s1_q;
    logic rq_s2_q;
    logic rq_s3_q;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rq_s1_q <= 1'b0;
            rq_s2_q <= 1'b0;
            rq_s3_q <= 1'b0;
        end else begin
            rq_s1_q <= req_tgl_q;
            rq_s2_q <= rq_s1_q;
            rq_s3_q <= rq_s2_q;
        end
    end
    wire acc = rq_s2_q ^ rq_s3_q;
    wire wr = acc && hold_q.we;
    wire rd = acc && !hold_q.we;
    wire [7:0] wd = hold_q.wdata;
    // Soft reset is decoded once per taken write, never from a stale word
    wire soft_rst = wr && hold_q.addr == `SMCR_A_CMD && wd == `SMCR_CMD_SOFTRESET;

    // Configuration storage; bits outside the masks are never written
    logic [7:0] fcfg_q;
    logic [7:0] intc_q;
    logic [7:0] pwr_q;
    logic [7:0] osr_q;
    logic [7:0] odr_q;
    logic [7:0] flags_q;
    logic wire3_q;
    logic wdt_en_q;
    logic wdt_sel_q;
    logic nvm_load_q;
    smcr_seq_e seq_q;
    // A forced run ends on the core's done pulse, not on a timer
    wire forced_done = seq_q == SMCR_FORCED && meas_done;

    // Plain config registers; masks keep unused bits at zero
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            fcfg_q <= `SMCR_RST_FIFOCFG;
            intc_q <= `SMCR_RST_INTCTL;
            osr_q <= `SMCR_RST_OSR;
            odr_q <= `SMCR_RST_ODR;
        end else if (soft_rst) begin
            fcfg_q <= `SMCR_RST_FIFOCFG;
            intc_q <= `SMCR_RST_INTCTL;
            osr_q <= `SMCR_RST_OSR;
            odr_q <= `SMCR_RST_ODR;
        end else if (wr) begin
            case (hold_q.addr)
                `SMCR_A_FIFOCFG: fcfg_q <= wd & `SMCR_M_FIFOCFG;
                `SMCR_A_INTCTL: intc_q <= wd & `SMCR_M_INTCTL;
                `SMCR_A_OSR: osr_q <= wd & `SMCR_M_OSR;
                `SMCR_A_ODR: begin
                    // Saturate so the stored value is what software reads
                    if ((wd & `SMCR_M_ODR) > {3'h0, `SMCR_ODR_MAX})
                        odr_q <= {3'h0, `SMCR_ODR_MAX};
                    else
                        odr_q <= wd & `SMCR_M_ODR;
                end
                default: ;
            endcase
        end
    end

    // Interface config; watchdog bits come back from the nonvolatile copy
    // nvm_wdt is static, so it is read here without synchronisers
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wire3_q <= `SMCR_RST_3WIRE;
            wdt_en_q <= 1'b0;
            wdt_sel_q <= 1'b0;
            nvm_load_q <= 1'b1;
        end else if (nvm_load_q || soft_rst) begin
            // Strap is sampled after reset release, never under reset
            nvm_load_q <= 1'b0;
            wire3_q <= `SMCR_RST_3WIRE;
            wdt_en_q <= nvm_wdt[0];
            wdt_sel_q <= nvm_wdt[1];
        end else if (wr && hold_q.addr == `SMCR_A_IFCFG) begin
            wire3_q <= wd[`SMCR_B_3WIRE];
            wdt_en_q <= wd[`SMCR_B_WDT_EN];
            wdt_sel_q <= wd[`SMCR_B_WDT_SEL];
        end
    end

    // Power control; a finished forced run drops mode back to sleep
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pwr_q <= `SMCR_RST_PWR;
        end else if (soft_rst) begin
            pwr_q <= `SMCR_RST_PWR;
        end else if (wr && hold_q.addr == `SMCR_A_PWR) begin
            pwr_q <= wd & `SMCR_M_PWR;
        end else if (forced_done) begin
            pwr_q[`SMCR_B_MODE_HI:`SMCR_B_MODE_LO] <= `SMCR_MODE_SLEEP;
        end
    end

    wire [1:0] mode = pwr_q[`SMCR_B_MODE_HI:`SMCR_B_MODE_LO];
    wire pen = pwr_q[`SMCR_B_PEN];
    wire ten = pwr_q[`SMCR_B_TEN];
    wire forced_mode = mode != `SMCR_MODE_SLEEP && mode != `SMCR_MODE_NORMAL;

    // Interrupt flags: gated by enables, set wins over clear-on-read
    // Flags stay sticky without the hold bit; only the pin follows it
    wire [7:0] ev_vec;
    assign ev_vec[`SMCR_F_FWM] = evt.fwm && intc_q[`SMCR_B_FWM_EN];
    assign ev_vec[`SMCR_F_FFULL] = evt.ffull && intc_q[`SMCR_B_FFULL_EN];
    assign ev_vec[2] = 1'b0;
    assign ev_vec[`SMCR_F_DRDY] = evt.drdy && intc_q[`SMCR_B_DRDY_EN];
    assign ev_vec[7:4] = 4'h0;
    wire rd_flags = rd && hold_q.addr == `SMCR_A_FLAGS;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            flags_q <= 8'h00;
        end else if (soft_rst) begin
            flags_q <= 8'h00;
        end else begin
            flags_q <= (rd_flags ? 8'h00 : flags_q) | ev_vec;
        end
    end

    // Read mux, sampled once per access and held for the link side
    // Command register has no storage and reads zero
    logic [7:0] rmux;
    always_comb begin
        case (hold_q.addr)
            `SMCR_A_FLAGS: rmux = flags_q;
            `SMCR_A_FIFOCFG: rmux = fcfg_q;
            `SMCR_A_INTCTL: rmux = intc_q;
            `SMCR_A_IFCFG: rmux = {5'h00, wdt_sel_q, wdt_en_q, wire3_q};
            `SMCR_A_PWR: rmux = pwr_q;
            `SMCR_A_OSR: rmux = osr_q;
            `SMCR_A_ODR: rmux = odr_q;
            default: rmux = 8'h00;
        endcase
    end
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= 8'h00;
            ack_tgl_q <= 1'b0;
        end else if (acc) begin
            rdata_q <= rmux;
            ack_tgl_q <= ~ack_tgl_q;
        end
    end

    // Interrupt pin: latched level or single-cycle pulse
    // Open-drain needs an outside pull-up to show the released level
    logic pin_act_q;
    logic irq_out_q;
    logic irq_oe_q;
    wire latch = intc_q[`SMCR_B_LATCH];
    wire pin_act = latch ? |flags_q : |ev_vec;
    wire pin_lvl = pin_act_q ~^ intc_q[`SMCR_B_LVL];
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pin_act_q <= 1'b0;
            irq_out_q <= 1'b1;
            irq_oe_q <= 1'b1;
        end else begin
            pin_act_q <= pin_act;
            // Open-drain only pulls low; high level is left to the pull-up
            if (intc_q[`SMCR_B_OD]) begin
                irq_out_q <= 1'b0;
                irq_oe_q <= !pin_lvl;
            end else begin
                irq_out_q <= pin_lvl;
                irq_oe_q <= 1'b1;
            end
        end
    end
    assign irq_out = irq_out_q;
    assign irq_oe = irq_oe_q;

    // Rate divider and measurement sequencer
    // A mode change restarts the divider, so the first period is whole
    logic [17:0] div_q;
    logic start_q;
    wire [17:0] div_lim = 18'(18'h1 << odr_q[`SMCR_B_RATE_HI:`SMCR_B_RATE_LO]) - 18'h1;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            div_q <= 18'h0;
        end else if (mode != `SMCR_MODE_NORMAL || soft_rst) begin
            div_q <= 18'h0;
        end else if (meas_tick) begin
            div_q <= (div_q >= div_lim) ? 18'h0 : div_q + 18'h1;
        end
    end
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            seq_q <= SMCR_IDLE;
            start_q <= 1'b0;
        end else begin
            start_q <= 1'b0;
            case (seq_q)
                SMCR_IDLE: begin
                    // With both channels off a forced request waits here
                    if (forced_mode && !soft_rst && (pen || ten)) begin
                        seq_q <= SMCR_FORCED;
                        start_q <= 1'b1;
                    end else if (mode == `SMCR_MODE_NORMAL && meas_tick
                                 && div_q >= div_lim && (pen || ten)) begin
                        start_q <= 1'b1;
                    end
                end
                SMCR_FORCED: begin
                    if (meas_done || soft_rst) seq_q <= SMCR_IDLE;
                end
                default: seq_q <= SMCR_IDLE;
            endcase
        end
    end
    assign meas_start = start_q;

    // FIFO decimation of incoming samples
    // The first sample after reset or soft reset is always pushed
    logic [6:0] dec_q;
    logic push_q;
    wire [6:0] dec_lim = 7'(8'(8'h1 << fcfg_q[`SMCR_B_SUB_HI:`SMCR_B_SUB_LO]) - 8'h1);
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            dec_q <= 7'h0;
            push_q <= 1'b0;
        end else begin
            push_q <= sample_in && dec_q == 7'h0;
            if (soft_rst) dec_q <= 7'h0;
            else if (sample_in) dec_q <= (dec_q >= dec_lim) ? 7'h0 : dec_q + 7'h1;
        end
    end
    assign fifo_push = push_q;
    assign filt_select = fcfg_q[`SMCR_B_SRC_HI:`SMCR_B_SRC_LO] == `SMCR_SRC_FILT;

    // Bus watchdog; counts while bus_active is high, restarted by bus_kick or an idle bus
    // Counts core clocks, so the timeouts hold only at the nominal mclk rate
    logic [31:0] wdt_q;
    logic wexp_q;
    wire [31:0] wdt_lim = wdt_sel_q ? 32'(WDT_LONG_CYC) : 32'(WDT_SHORT_CYC);
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wdt_q <= 32'h0;
            wexp_q <= 1'b0;
        end else begin
            wexp_q <= 1'b0;
            if (!wdt_en_q || !bus_active || bus_kick) begin
                wdt_q <= 32'h0;
            end else if (wdt_q >= wdt_lim - 32'h1) begin
                wdt_q <= 32'h0;
                wexp_q <= 1'b1;
            end else begin
                wdt_q <= wdt_q + 32'h1;
            end
        end
    end
    assign wdt_expire = wexp_q;

    // Level outputs come straight from the registers
    assign three_wire_select = wire3_q;
    assign press_conv_en = pen;
    assign temperature_conv_en = ten;
    assign press_oversample = osr_q[`SMCR_B_OSP_HI:`SMCR_B_OSP_LO];
    assign temperature_oversample = osr_q[`SMCR_B_OST_HI:`SMCR_B_OST_LO];
endmodule
`default_nettype wire

// ===== src/smcr_defines.svh
// Offsets, field positions, reset values and timing for the config bank.
// Assumes inclusion by bare name from the package and the bank module.
`ifndef SMCR_DEFINES_SVH
`define SMCR_DEFINES_SVH

// Register offsets
`define SMCR_A_FLAGS 8'h11
`define SMCR_A_FIFOCFG 8'h18
`define SMCR_A_INTCTL 8'h19
`define SMCR_A_IFCFG 8'h1a
`define SMCR_A_PWR 8'h1b
`define SMCR_A_OSR 8'h1c
`define SMCR_A_ODR 8'h1d
`define SMCR_A_CMD 8'h7e
`define SMCR_CMD_SOFTRESET 8'hb6

// Writable bit masks
`define SMCR_M_FIFOCFG 8'h1f
`define SMCR_M_INTCTL 8'h5f
`define SMCR_M_IFCFG 8'h07
`define SMCR_M_PWR 8'h33
`define SMCR_M_OSR 8'h3f
`define SMCR_M_ODR 8'h1f

// Reset values
`define SMCR_RST_FIFOCFG 8'h00
`define SMCR_RST_INTCTL 8'h00
`define SMCR_RST_3WIRE 1'b0
`define SMCR_RST_PWR 8'h00
`define SMCR_RST_OSR 8'h00
`define SMCR_RST_ODR 8'h00

// Field positions
`define SMCR_B_OD 0
`define SMCR_B_LVL 1
`define SMCR_B_LATCH 2
`define SMCR_B_FWM_EN 3
`define SMCR_B_FFULL_EN 4
`define SMCR_B_DRDY_EN 6
`define SMCR_F_FWM 0
`define SMCR_F_FFULL 1
`define SMCR_F_DRDY 3
`define SMCR_B_3WIRE 0
`define SMCR_B_WDT_EN 1
`define SMCR_B_WDT_SEL 2
`define SMCR_B_PEN 0
`define SMCR_B_TEN 1
`define SMCR_B_MODE_HI 5
`define SMCR_B_MODE_LO 4
`define SMCR_B_SUB_HI 2
`define SMCR_B_SUB_LO 0
`define SMCR_B_SRC_HI 4
`define SMCR_B_SRC_LO 3
`define SMCR_B_OSP_HI 2
`define SMCR_B_OSP_LO 0
`define SMCR_B_OST_HI 5
`define SMCR_B_OST_LO 3
`define SMCR_B_RATE_HI 4
`define SMCR_B_RATE_LO 0

// Mode and data source codes, highest rate code
`define SMCR_MODE_SLEEP 2'h0
`define SMCR_MODE_NORMAL 2'h3
`define SMCR_SRC_FILT 2'h1
`define SMCR_ODR_MAX 5'h11

// Watchdog times in microseconds, the short one in hundredths of them, clock in MHz
`define SMCR_CLK_MHZ 100
`define SMCR_WDT_SHORT_US_X100 125000
`define SMCR_WDT_LONG_US 40000
`endif

// ===== src/smcr_pkg.sv
// Types shared by the sensor config bank.
// Assumes smcr_defines.svh on the include path.
`include "smcr_defines.svh"
package smcr_pkg;
    // One register access from the serial engine
    typedef struct packed {
        logic we;
        logic [7:0] addr;
        logic [7:0] wdata;
    } smcr_req_s;

    // Per-sample events from the measurement core
    typedef struct packed {
        logic fwm;
        logic ffull;
        logic drdy;
    } smcr_evt_s;

    typedef enum logic [0:0] {
        SMCR_IDLE = 1'b0,
        SMCR_FORCED = 1'b1
    } smcr_seq_e;
endpackage

// ===== tb/smcr_regs_chk.sv
// Port-level assertions for the sensor config bank.
// Assumes it is bound onto smcr_regs with the same watchdog parameters.
`timescale 1ns/1ps
`default_nettype none
module smcr_regs_chk
#(
    parameter int WDT_SHORT_CYC = 20,
    parameter int WDT_LONG_CYC = 50
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic lclk,
    input wire logic lk_req,
    input wire logic lk_busy,
    input wire logic lk_rvalid,
    input wire logic sample_in,
    input wire logic bus_active,
    input wire logic fifo_push,
    input wire logic press_conv_en,
    input wire logic temperature_conv_en,
    input wire logic meas_start,
    input wire logic wdt_expire,
    input wire logic irq_out,
    input wire logic irq_oe
);
    logic [31:0] gap_q;

    // Cycles since last expiry; a lower bound only, idle time also counts
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            gap_q <= 32'h0;
        end else if (wdt_expire) begin
            gap_q <= 32'h0;
        end else begin
            gap_q <= gap_q + 32'h1;
        end
    end

    push_cause_a: assert property (@(posedge mclk) disable iff (!rst_n)
        fifo_push |-> $past(sample_in)) else $error("fifo push without sample");
    pin_release_a: assert property (@(posedge mclk) disable iff (!rst_n)
        !irq_oe |-> !irq_out) else $error("released pin drives high");
    meas_gate_a: assert property (@(posedge mclk) disable iff (!rst_n)
        meas_start |-> $past(press_conv_en | temperature_conv_en))
        else $error("measurement with both channels off");
    wdt_cause_a: assert property (@(posedge mclk) disable iff (!rst_n)
        wdt_expire |-> $past(bus_active)) else $error("watchdog expiry without bus activity");
    wdt_gap_a: assert property (@(posedge mclk) disable iff (!rst_n)
        wdt_expire |-> gap_q >= WDT_SHORT_CYC - 2) else $error("watchdog expiry too early");
    link_take_a: assert property (@(posedge lclk) disable iff (!rst_n)
        lk_req && !lk_busy |=> lk_busy) else $error("request not taken");
    link_answer_a: assert property (@(posedge lclk) disable iff (!rst_n)
        $rose(lk_busy) |-> ##[2:6] !lk_busy) else $error("link answer late");
    read_answer_a: assert property (@(posedge lclk) disable iff (!rst_n)
        lk_rvalid |-> !lk_busy && $past(lk_busy)) else $error("read data outside answer");
endmodule
`default_nettype wire

// ===== tb/smcr_host_model.sv
// Host controller model issuing single-byte register accesses on the link.
// Assumes the caller waits three link edges after reset release.
`timescale 1ns/1ps
`default_nettype none
module smcr_host_model
    import smcr_pkg::*;
(
    input wire logic lclk,
    input wire logic lk_busy,
    input wire logic lk_rvalid,
    input wire logic [7:0] lk_rdata,
    output logic lk_req,
    output smcr_req_s lk_cmd
);
    initial begin
        lk_req = 1'b0;
        lk_cmd = '0;
    end

    // One access: request held to the taking edge, answer taken at busy fall
    task automatic xfer(input logic we, input logic [7:0] addr, input logic [7:0] wdata,
            output logic [7:0] rdata);
        rdata = 8'hxx;
        @(posedge lclk);
        lk_req <= 1'b1;
        lk_cmd <= {we, addr, wdata};
        @(posedge lclk);
        lk_req <= 1'b0;
        // Released lines flip so a stale command cannot pass as valid
        lk_cmd <= ~lk_cmd;
        for (int n = 0; n < 12; n++) begin
            @(posedge lclk);
            #1;
            if (lk_busy === 1'b0) begin
                if (!we && lk_rvalid === 1'b1) rdata = lk_rdata;
                break;
            end
        end
    endtask
endmodule
`default_nettype wire

// ===== tb/smcr_regs_tb_top.sv
// Self-checking bench for the sensor config bank.
// Assumes the host model and checker are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
module smcr_regs_tb_top
    import smcr_pkg::*;
;
    localparam int WS = 20;
    localparam int WL = 50;
    logic mclk, lclk, rst_n, lk_req, lk_busy, lk_rvalid, sample_in, meas_tick, meas_done;
    logic bus_active, bus_kick, fifo_push, filt_select, three_wire_select, press_conv_en;
    logic temperature_conv_en, meas_start, wdt_expire, irq_out, irq_oe;
    logic [7:0] lk_rdata;
    logic [2:0] press_oversample, temperature_oversample;
    smcr_req_s lk_cmd;
    smcr_evt_s evt;
    logic [1:0] nvm_wdt;
    int num_errors = 0;
    int check_count = 0;
    int push_n, start_n, wdt_n;

    smcr_regs #(.WDT_SHORT_CYC(WS), .WDT_LONG_CYC(WL)) uut (.mclk(mclk), .rst_n(rst_n),
        .lclk(lclk), .lk_req(lk_req), .lk_cmd(lk_cmd), .lk_busy(lk_busy),
        .lk_rvalid(lk_rvalid), .lk_rdata(lk_rdata), .evt(evt), .sample_in(sample_in),
        .meas_tick(meas_tick), .meas_done(meas_done), .bus_active(bus_active),
        .bus_kick(bus_kick), .nvm_wdt(nvm_wdt), .fifo_push(fifo_push),
        .filt_select(filt_select), .three_wire_select(three_wire_select),
        .press_conv_en(press_conv_en), .temperature_conv_en(temperature_conv_en),
        .press_oversample(press_oversample), .temperature_oversample(temperature_oversample),
        .meas_start(meas_start), .wdt_expire(wdt_expire), .irq_out(irq_out), .irq_oe(irq_oe));
    smcr_host_model host (.lclk(lclk), .lk_busy(lk_busy), .lk_rvalid(lk_rvalid),
        .lk_rdata(lk_rdata), .lk_req(lk_req), .lk_cmd(lk_cmd));

    // Clocks; half periods chosen so rising edges never coincide
    always #5 mclk = ~mclk;
    always #80 lclk = ~lclk;

    // Output pulse counters
    always @(posedge mclk) begin
        if (fifo_push === 1'b1) push_n++;
        if (meas_start === 1'b1) start_n++;
        if (wdt_expire === 1'b1) wdt_n++;
    end

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] r;
        host.xfer(1'b1, a, d, r);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] r;
        host.xfer(1'b0, a, 8'h00, r);
        check($sformatf("reg %h", a), r, e);
    endtask
    task automatic mcyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    // Pulses on {meas_done, meas_tick, sample_in}, three cycles apart
    task automatic pulses(input logic [2:0] sel, input int n);
        repeat (n) begin
            @(posedge mclk);
            {meas_done, meas_tick, sample_in} <= sel;
            @(posedge mclk);
            {meas_done, meas_tick, sample_in} <= 3'h0;
            @(posedge mclk);
        end
    endtask
    task automatic evt_pulse(input smcr_evt_s e);
        @(posedge mclk);
        evt <= e;
        @(posedge mclk);
        evt <= '0;
    endtask
    task automatic t_reset();
        logic [7:0] a[8] = '{8'h18, 8'h19, 8'h1a, 8'h1b, 8'h1c, 8'h1d, 8'h11, 8'h7e};
        foreach (a[i]) rchk(a[i], 8'h00);
        check("irq idle", {6'h0, irq_out, irq_oe}, 8'h03);
    endtask
    task automatic t_regs();
        logic [7:0] a[6] = '{8'h18, 8'h19, 8'h1a, 8'h1b, 8'h1c, 8'h1d};
        logic [7:0] m[6] = '{8'h1f, 8'h5f, 8'h07, 8'h33, 8'h3f, 8'h11};
        logic [7:0] ov[3] = '{8'h10, 8'h11, 8'h12};
        foreach (a[i]) wr(a[i], 8'hff);
        foreach (a[i]) rchk(a[i], m[i]);
        mcyc(4);
        check("wire3", {7'h0, three_wire_select}, 8'h01);
        check("conv", {6'h0, press_conv_en, temperature_conv_en}, 8'h03);
        wr(8'h20, 8'hff);
        rchk(8'h20, 8'h00);
        foreach (ov[i]) begin
            wr(8'h1d, ov[i]);
            rchk(8'h1d, (ov[i] > 8'h11) ? 8'h11 : ov[i]);
        end
        wr(8'h7e, 8'hb6);
        t_reset();
    endtask
    task automatic t_fields();
        for (int s = 0; s < 4; s++) begin
            wr(8'h18, 8'(s << 3));
            mcyc(4);
            check("filt", {7'h0, filt_select}, (s == 1) ? 8'h01 : 8'h00);
        end
        wr(8'h1c, 8'h2c);
        mcyc(4);
        check("osr", {2'h0, temperature_oversample, press_oversample}, 8'h2c);
    endtask
    task automatic t_events();
        int eb[3] = '{3, 4, 6};
        int fb[3] = '{0, 1, 3};
        for (int i = 0; i < 3; i++) begin
            wr(8'h19, 8'h01 << eb[i]);
            evt_pulse(3'h7);
            mcyc(3);
            rchk(8'h11, 8'h01 << fb[i]);
            rchk(8'h11, 8'h00);
        end
    endtask
    task automatic t_pin();
        evt_pulse(3'h1);
        mcyc(1);
        check("pulse low", {7'h0, irq_out}, 8'h00);
        mcyc(3);
        check("pulse end", {7'h0, irq_out}, 8'h01);
        rchk(8'h11, 8'h08);
        wr(8'h19, 8'h46);
        evt_pulse(3'h1);
        mcyc(10);
        check("held high", {7'h0, irq_out}, 8'h01);
        rchk(8'h11, 8'h08);
        mcyc(4);
        check("released", {7'h0, irq_out}, 8'h00);
        wr(8'h19, 8'h45);
        mcyc(4);
        check("od idle", {6'h0, irq_out, irq_oe}, 8'h00);
        evt_pulse(3'h1);
        mcyc(10);
        check("od active", {6'h0, irq_out, irq_oe}, 8'h01);
        rchk(8'h11, 8'h08);
    endtask
    task automatic t_meas();
        logic [7:0] pw[4] = '{8'h31, 8'h31, 8'h01, 8'h30};
        logic [7:0] od[4] = '{8'h00, 8'h02, 8'h00, 8'h00};
        int ex[4] = '{8, 2, 0, 0};
        for (int d = 0; d < 3; d += 2) begin
            wr(8'h18, 8'(d));
            push_n = 0;
            pulses(3'h1, 8);
            mcyc(2);
            check("pushes", 8'(push_n), 8'(8 >> d));
        end
        foreach (pw[i]) begin
            wr(8'h1d, od[i]);
            wr(8'h1b, pw[i]);
            mcyc(4);
            start_n = 0;
            pulses(3'h2, 8);
            mcyc(3);
            check("starts", 8'(start_n), 8'(ex[i]));
        end
        for (int m = 1; m < 3; m++) begin
            start_n = 0;
            wr(8'h1b, 8'(m << 4) | 8'h01);
            mcyc(6);
            check("forced", 8'(start_n), 8'h01);
            pulses(3'h4, 1);
            mcyc(4);
            rchk(8'h1b, 8'h01);
        end
    endtask
    task automatic t_wdt();
        logic [7:0] c[3] = '{8'h00, 8'h06, 8'h02};
        int ex[3] = '{0, 0, 1};
        foreach (c[i]) begin
            wr(8'h1a, c[i]);
            @(posedge mclk);
            bus_kick <= 1'b1;
            @(posedge mclk);
            bus_kick <= 1'b0;
            wdt_n = 0;
            bus_active <= 1'b1;
            repeat (30) @(posedge mclk);
            bus_active <= 1'b0;
            mcyc(2);
            check("wdt", 8'(wdt_n), 8'(ex[i]));
        end
        // Soft reset reloads both watchdog bits from the nonvolatile copy
        @(posedge mclk);
        nvm_wdt <= 2'h3;
        wr(8'h7e, 8'hb6);
        rchk(8'h1a, 8'h06);
    endtask
    task automatic results();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Hang guard, well beyond the expected run of some 6300 cycles
    initial begin
        repeat (80000) @(posedge mclk);
        num_errors++;
        $display("watchdog ran out");
        results();
    end

    initial begin
        mclk = 1'b0;
        lclk = 1'b0;
        rst_n = 1'b0;
        evt = '0;
        nvm_wdt = 2'h0;
        {meas_done, meas_tick, sample_in, bus_active, bus_kick} = 5'h0;
        repeat (16) @(posedge mclk);
        repeat (2) @(posedge lclk);
        @(posedge mclk);
        rst_n <= 1'b1;
        repeat (3) @(posedge lclk);
        t_reset();
        t_regs();
        t_fields();
        t_events();
        t_pin();
        t_meas();
        t_wdt();
        results();
    end
endmodule

bind smcr_regs smcr_regs_chk #(.WDT_SHORT_CYC(WDT_SHORT_CYC), .WDT_LONG_CYC(WDT_LONG_CYC)) chk (
    .mclk(mclk), .rst_n(rst_n), .lclk(lclk), .lk_req(lk_req), .lk_busy(lk_busy),
    .lk_rvalid(lk_rvalid), .sample_in(sample_in), .bus_active(bus_active),
    .fifo_push(fifo_push), .press_conv_en(press_conv_en),
    .temperature_conv_en(temperature_conv_en), .meas_start(meas_start),
    .wdt_expire(wdt_expire), .irq_out(irq_out), .irq_oe(irq_oe));
`default_nettype wire
